// ==== logic/cxf_defines.svh ====
// Constants of the transceiver fault-control block: offsets, fields, timing.
// Assumes a 200 MHz system clock and AXI4-Lite register access.
// What this block does
// - Bus dominant means low on transmit and receive; recessive means high.
// - Dominant timeout supervision runs only in normal mode.
// - Each transmit falling edge in normal mode starts the dominant timeout measurement.
// - No rising edge within at least 1.2 ms disables the bus driver.
// - Transmit back at recessive clears the timeout fault, re-enables driver.
// - Receiver keeps following the bus during a dominant timeout fault.
// - Thermal fault turns driver off, blocks transmit path, receive stays.
// - Thermal fault clears below threshold, re-enters on rise, with hysteresis.
// - Interface undervoltage, or main undervoltage without standby, puts the device in a protected state.
// - Main supply low, interface ok, standby low: protected, bus high-z, receive recessive.
// - Receive output driven only while the interface supply is present.
// - Standby biases both bus lines weakly toward ground.
// - Standby high: driver off, receive high until wake; low: normal mode after the mode-change time.
// - After undervoltage clears, normal follows mode-change time; controller waits.
`ifndef CXF_DEFINES_SVH
`define CXF_DEFINES_SVH

// Timing
`define CXF_CLK_PERIOD_NS    5
`define CXF_DTO_PERIOD_NS    1200000
`define CXF_MODE_CHANGE_NS   20000
`define CXF_TSD_RELEASE_NS   1000
`define CXF_DTO_CNT_W        18
`define CXF_MODE_CNT_W       12
`define CXF_TSD_CNT_W        8
`define CXF_CEIL_CYCLES(ns)  (((ns) + `CXF_CLK_PERIOD_NS - 1) / `CXF_CLK_PERIOD_NS)

// Register map
`define CXF_AXI_AW           8
`define CXF_ADDR_CTRL        8'h00
`define CXF_ADDR_STATUS      8'h04
`define CXF_ADDR_IRQ_STATUS  8'h08
`define CXF_ADDR_IRQ_MASK    8'h0c
`define CXF_RESP_OKAY        2'h0
`define CXF_RESP_SLVERR      2'h2

// Control fields
`define CXF_CTRL_W           2
`define CXF_CTRL_FORCE_STB   0
`define CXF_CTRL_DRV_KILL    1
`define CXF_CTRL_RESET       2'h0

// Status fields
`define CXF_ST_MODE_LO       0
`define CXF_ST_MODE_HI       1
`define CXF_ST_MAIN_OK       2
`define CXF_ST_IFACE_OK      3
`define CXF_ST_DTO           4
`define CXF_ST_TSD           5
`define CXF_ST_DRV_EN        6

// Interrupt events
`define CXF_IRQ_W            4
`define CXF_IRQ_DTO          0
`define CXF_IRQ_TSD          1
`define CXF_IRQ_UV           2
`define CXF_IRQ_WAKE         3
`define CXF_IRQ_RESET        4'h0

`endif

// ==== logic/cxf_dto_timer.sv ====
// Dominant timeout supervision of the transmit input.
// Assumes transmit input synchronous to the clock.
`include "cxf_defines.svh"
module cxf_dto_timer #(
  parameter int DTO_CYCLES = `CXF_CEIL_CYCLES(`CXF_DTO_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Guard signals
  cxf_guard_if.dto_mp     guard
);
  import cxf_pkg::*;

  logic                      txd_low_prev;
  logic                      running;
  logic [`CXF_DTO_CNT_W-1:0] count;
  logic                      fall_edge;

  assign fall_edge = guard.txd_low & ~txd_low_prev & guard.dto_enable;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      txd_low_prev <= 1'b0;
    end else begin
      txd_low_prev <= guard.txd_low;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      running <= 1'b0;
      count   <= '0;
    end else if (fall_edge) begin
      running <= 1'b1;
      count   <= '0;
    end else if (!guard.txd_low || !guard.dto_enable) begin
      running <= 1'b0;
      count   <= '0;
    end else if (running && count != `CXF_DTO_CNT_W'(DTO_CYCLES - 1)) begin
      count   <= count + `CXF_DTO_CNT_W'(1);
    end
  end

  // Sticky until transmit returns high; leaving normal mode also clears it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      guard.dto_fault <= 1'b0;
    end else if (!guard.txd_low || !guard.dto_enable) begin
      guard.dto_fault <= 1'b0;
    end else if (running && count == `CXF_DTO_CNT_W'(DTO_CYCLES - 1)) begin
      guard.dto_fault <= 1'b1;
    end
  end

endmodule : cxf_dto_timer

// ==== logic/cxf_guard_if.sv ====
// Signals between the top and its two protection submodules.
// Assumes all members are sampled on the system clock.
interface cxf_guard_if;
  logic txd_low;
  logic dto_enable;
  logic dto_fault;
  logic thermal_trip;
  logic tsd_fault;

  modport dto_mp (input txd_low, input dto_enable, output dto_fault);
  modport tsd_mp (input thermal_trip, output tsd_fault);
  modport top_mp (output txd_low, output dto_enable, output thermal_trip,
                  input dto_fault, input tsd_fault);
endinterface : cxf_guard_if

// ==== logic/cxf_pkg.sv ====
// Types shared by the transceiver fault-control block.
// Assumes nothing beyond a SystemVerilog elaborator.
package cxf_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_PROTECTED,
    MODE_SETTLING
  } cxf_mode_e;

  typedef enum logic [1:0] {
    BIAS_MID,
    BIAS_GND,
    BIAS_HIZ
  } cxf_bias_e;

endpackage : cxf_pkg

// ==== logic/cxf_thermal_guard.sv ====
// Thermal shutdown latch with release hysteresis.
// Assumes a level that is high while the die is over its trip threshold.
`include "cxf_defines.svh"
module cxf_thermal_guard (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Guard signals
  cxf_guard_if.tsd_mp     guard
);
  import cxf_pkg::*;

  localparam int RELEASE_CYCLES = `CXF_CEIL_CYCLES(`CXF_TSD_RELEASE_NS);

  logic [`CXF_TSD_CNT_W-1:0] cool_count;

  // Cool time must be continuous, so a chattering sensor cannot toggle the driver
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cool_count <= '0;
    end else if (guard.thermal_trip || !guard.tsd_fault) begin
      cool_count <= '0;
    end else begin
      cool_count <= cool_count + `CXF_TSD_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      guard.tsd_fault <= 1'b0;
    end else if (guard.thermal_trip) begin
      guard.tsd_fault <= 1'b1;
    end else if (cool_count == `CXF_TSD_CNT_W'(RELEASE_CYCLES - 1)) begin
      guard.tsd_fault <= 1'b0;
    end
  end

endmodule : cxf_thermal_guard

// ==== logic/cxf_top.sv ====
// Top of the transceiver fault-control block: modes, protection, registers.
// Assumes all pin inputs synchronous to CLOCK_IN; analog stages outside.
`include "cxf_defines.svh"
module cxf_top #(
  parameter int DTO_CYCLES = `CXF_CEIL_CYCLES(`CXF_DTO_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic                   CLOCK_IN,
  input  wire logic                   SYS_RST_IN,
  // Controller side
  input  wire logic                   TXD_IN,
  input  wire logic                   STANDBY_SELECT_IN,
  output logic                        RXD_OUT,
  output logic                        RXD_OE_OUT,
  // Analog front end
  input  wire logic                   BUS_RX_DOMINANT_IN,
  input  wire logic                   WAKE_DOMINANT_IN,
  input  wire logic                   THERMAL_TRIP_IN,
  input  wire logic                   MAIN_SUPPLY_OK_IN,
  input  wire logic                   IFACE_SUPPLY_OK_IN,
  output logic                        DRIVER_EN_OUT,
  output logic                        BUS_DOMINANT_OUT,
  output cxf_pkg::cxf_bias_e          BUS_BIAS_OUT,
  // Interrupt
  output logic                        IRQ_OUT,
  // AXI4-Lite write
  input  wire logic [`CXF_AXI_AW-1:0] AXI_AWADDR_IN,
  input  wire logic                   AXI_AWVALID_IN,
  output logic                        AXI_AWREADY_OUT,
  input  wire logic [31:0]            AXI_WDATA_IN,
  input  wire logic [3:0]             AXI_WSTRB_IN,
  input  wire logic                   AXI_WVALID_IN,
  output logic                        AXI_WREADY_OUT,
  output logic [1:0]                  AXI_BRESP_OUT,
  output logic                        AXI_BVALID_OUT,
  input  wire logic                   AXI_BREADY_IN,
  // AXI4-Lite read
  input  wire logic [`CXF_AXI_AW-1:0] AXI_ARADDR_IN,
  input  wire logic                   AXI_ARVALID_IN,
  output logic                        AXI_ARREADY_OUT,
  output logic [31:0]                 AXI_RDATA_OUT,
  output logic [1:0]                  AXI_RRESP_OUT,
  output logic                        AXI_RVALID_OUT,
  input  wire logic                   AXI_RREADY_IN
);
  import cxf_pkg::*;

  localparam int MODE_CYCLES = `CXF_CEIL_CYCLES(`CXF_MODE_CHANGE_NS);

  cxf_guard_if guard ();

  cxf_mode_e                  mode;
  cxf_mode_e                  next_mode;
  logic [`CXF_MODE_CNT_W-1:0] mode_count;
  logic                       standby_req;
  logic                       next_drv_en;
  logic                       next_rxd;
  logic                       dto_prev;
  logic                       tsd_prev;
  logic                       wake_prev;
  logic [`CXF_CTRL_W-1:0]     ctrl;
  logic [`CXF_IRQ_W-1:0]      irq_status;
  logic [`CXF_IRQ_W-1:0]      irq_mask;
  logic [`CXF_IRQ_W-1:0]      irq_event;
  logic [`CXF_IRQ_W-1:0]      irq_clear;
  logic [`CXF_IRQ_W-1:0]      next_irq_status;
  logic                       aw_held;
  logic                       w_held;
  logic [`CXF_AXI_AW-1:0]     aw_addr;
  logic [31:0]                w_data;
  logic                       w_lane0;
  logic                       wr_fire;
  logic                       wr_hit;
  logic [31:0]                rd_word;
  logic                       rd_hit;

  // Protection submodules
  assign guard.txd_low      = ~TXD_IN;
  assign guard.dto_enable   = (mode == MODE_NORMAL);
  assign guard.thermal_trip = THERMAL_TRIP_IN;

  cxf_dto_timer #(
    .DTO_CYCLES (DTO_CYCLES)
  ) u_dto (
    .clk_in     (CLOCK_IN),
    .rst_in     (SYS_RST_IN),
    .guard      (guard.dto_mp)
  );

  cxf_thermal_guard u_tsd (
    .clk_in     (CLOCK_IN),
    .rst_in     (SYS_RST_IN),
    .guard      (guard.tsd_mp)
  );

  // Software can force standby on top of the pin
  assign standby_req = STANDBY_SELECT_IN | ctrl[`CXF_CTRL_FORCE_STB];

  // Mode selection; interface supply loss outranks everything
  always_comb begin
    next_mode = mode;
    if (!IFACE_SUPPLY_OK_IN) begin
      next_mode = MODE_PROTECTED;
    end else if (standby_req) begin
      next_mode = MODE_STANDBY;
    end else if (!MAIN_SUPPLY_OK_IN) begin
      next_mode = MODE_PROTECTED;
    end else begin
      unique case (mode)
        MODE_NORMAL: begin
          next_mode = MODE_NORMAL;
        end
        MODE_SETTLING: begin
          if (mode_count == `CXF_MODE_CNT_W'(MODE_CYCLES - 1)) begin
            next_mode = MODE_NORMAL;
          end
        end
        MODE_STANDBY, MODE_PROTECTED: begin
          next_mode = MODE_SETTLING;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mode <= MODE_PROTECTED;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mode_count <= '0;
    end else if (mode != MODE_SETTLING || next_mode != MODE_SETTLING) begin
      mode_count <= '0;
    end else begin
      mode_count <= mode_count + `CXF_MODE_CNT_W'(1);
    end
  end

  // Driver path: both faults and the kill bit block it
  assign next_drv_en = (next_mode == MODE_NORMAL) & ~guard.dto_fault
                     & ~guard.tsd_fault & ~ctrl[`CXF_CTRL_DRV_KILL];

  // Receive path ignores the driver faults
  always_comb begin
    unique case (next_mode)
      MODE_NORMAL:  next_rxd = ~BUS_RX_DOMINANT_IN;
      MODE_STANDBY: next_rxd = ~WAKE_DOMINANT_IN;
      default:      next_rxd = 1'b1;
    endcase
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      DRIVER_EN_OUT    <= 1'b0;
      BUS_DOMINANT_OUT <= 1'b0;
    end else begin
      DRIVER_EN_OUT    <= next_drv_en;
      BUS_DOMINANT_OUT <= next_drv_en & ~TXD_IN;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RXD_OUT    <= 1'b1;
      RXD_OE_OUT <= 1'b0;
    end else begin
      RXD_OUT    <= next_rxd;
      RXD_OE_OUT <= IFACE_SUPPLY_OK_IN;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      BUS_BIAS_OUT <= BIAS_HIZ;
    end else begin
      unique case (next_mode)
        MODE_STANDBY:   BUS_BIAS_OUT <= BIAS_GND;
        MODE_PROTECTED: BUS_BIAS_OUT <= BIAS_HIZ;
        default:        BUS_BIAS_OUT <= BIAS_MID;
      endcase
    end
  end

  // Event edges for the interrupt logic
  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dto_prev  <= 1'b0;
      tsd_prev  <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      dto_prev  <= guard.dto_fault;
      tsd_prev  <= guard.tsd_fault;
      wake_prev <= WAKE_DOMINANT_IN;
    end
  end

  always_comb begin
    irq_event                = '0;
    irq_event[`CXF_IRQ_DTO]  = guard.dto_fault & ~dto_prev;
    irq_event[`CXF_IRQ_TSD]  = guard.tsd_fault & ~tsd_prev;
    irq_event[`CXF_IRQ_UV]   = (next_mode == MODE_PROTECTED) & (mode != MODE_PROTECTED);
    irq_event[`CXF_IRQ_WAKE] = (mode == MODE_STANDBY) & WAKE_DOMINANT_IN & ~wake_prev;
  end

  // Write-one-to-clear; a new event in the clearing cycle survives
  assign irq_clear = (wr_fire && wr_hit && aw_addr == `CXF_ADDR_IRQ_STATUS && w_lane0)
                   ? w_data[`CXF_IRQ_W-1:0] : '0;
  assign next_irq_status = (irq_status & ~irq_clear) | irq_event;

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_status <= `CXF_IRQ_RESET;
      IRQ_OUT    <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      IRQ_OUT    <= |(next_irq_status & irq_mask);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wr_fire = aw_held & w_held & ~AXI_BVALID_OUT;
  // Lane 0 masking is done at capture, so any held word may land
  assign w_lane0 = w_held;
  assign wr_hit  = (aw_addr == `CXF_ADDR_CTRL) || (aw_addr == `CXF_ADDR_STATUS)
                || (aw_addr == `CXF_ADDR_IRQ_STATUS) || (aw_addr == `CXF_ADDR_IRQ_MASK);

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_held         <= 1'b0;
      aw_addr         <= '0;
      AXI_AWREADY_OUT <= 1'b1;
    end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      aw_held         <= 1'b1;
      aw_addr         <= AXI_AWADDR_IN;
      AXI_AWREADY_OUT <= 1'b0;
    end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
      AXI_AWREADY_OUT <= 1'b1;
    end else if (wr_fire) begin
      aw_held         <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      w_held         <= 1'b0;
      w_data         <= '0;
      AXI_WREADY_OUT <= 1'b1;
    end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      w_held         <= 1'b1;
      w_data         <= AXI_WSTRB_IN[0] ? AXI_WDATA_IN : '0;
      AXI_WREADY_OUT <= 1'b0;
    end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
      AXI_WREADY_OUT <= 1'b1;
    end else if (wr_fire) begin
      w_held         <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT  <= `CXF_RESP_OKAY;
    end else if (wr_fire) begin
      AXI_BVALID_OUT <= 1'b1;
      AXI_BRESP_OUT  <= wr_hit ? `CXF_RESP_OKAY : `CXF_RESP_SLVERR;
    end else if (AXI_BREADY_IN) begin
      AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Registers that software writes
  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl     <= `CXF_CTRL_RESET;
      irq_mask <= `CXF_IRQ_RESET;
    end else if (wr_fire && w_lane0) begin
      if (aw_addr == `CXF_ADDR_CTRL) begin
        ctrl <= w_data[`CXF_CTRL_W-1:0];
      end
      if (aw_addr == `CXF_ADDR_IRQ_MASK) begin
        irq_mask <= w_data[`CXF_IRQ_W-1:0];
      end
    end
  end

  // AXI4-Lite read
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (AXI_ARADDR_IN)
      `CXF_ADDR_CTRL: begin
        rd_word[`CXF_CTRL_W-1:0] = ctrl;
      end
      `CXF_ADDR_STATUS: begin
        rd_word[`CXF_ST_MODE_HI:`CXF_ST_MODE_LO] = mode;
        rd_word[`CXF_ST_MAIN_OK]  = MAIN_SUPPLY_OK_IN;
        rd_word[`CXF_ST_IFACE_OK] = IFACE_SUPPLY_OK_IN;
        rd_word[`CXF_ST_DTO]      = guard.dto_fault;
        rd_word[`CXF_ST_TSD]      = guard.tsd_fault;
        rd_word[`CXF_ST_DRV_EN]   = DRIVER_EN_OUT;
      end
      `CXF_ADDR_IRQ_STATUS: begin
        rd_word[`CXF_IRQ_W-1:0] = irq_status;
      end
      `CXF_ADDR_IRQ_MASK: begin
        rd_word[`CXF_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT  <= 1'b0;
      AXI_RDATA_OUT   <= '0;
      AXI_RRESP_OUT   <= `CXF_RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT  <= 1'b1;
      AXI_RDATA_OUT   <= rd_word;
      AXI_RRESP_OUT   <= rd_hit ? `CXF_RESP_OKAY : `CXF_RESP_SLVERR;
    end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT  <= 1'b0;
    end
  end

endmodule : cxf_top

// ==== tb/cxf_ctrl_model.sv ====
// Model of the local protocol controller: transmit and standby lines.
// Assumes the bench calls its tasks from the clock's rising edge.
module cxf_ctrl_model (
  // Clock
  input  wire logic clk_in,
  // Pins toward the transceiver
  output logic      txd_out,
  output logic      stb_out
);
  // Idle recessive, standby low: normal only until told otherwise
  initial begin
    txd_out = 1'h1;
    stb_out = 1'h0;
  end

  task automatic put(input logic t, input logic s);
    @(posedge clk_in);
    txd_out <= t;
    stb_out <= s;
  endtask : put

  // Eleven bits must end before the timeout, so bit_cyc stays short
  task automatic frame(input logic [10:0] bits, input int bit_cyc);
    for (int i = 0; i < 11; i++) begin
      put(bits[i], stb_out);
      repeat (bit_cyc - 1) @(posedge clk_in);
    end
    put(1'h1, stb_out);
  endtask : frame
endmodule : cxf_ctrl_model

// ==== tb/cxf_top_bench.sv ====
// Self-checking bench of cxf_top: pins, modes, faults, registers.
// Assumes a short timeout parameter and the controller model.
module cxf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cxf_pkg::*;
  localparam int DTO = 20;
  localparam int SETTLE = 4010;
  logic clk = 0, rst = 1, txd, stb, rxd, rxd_oe, drv_en, bus_dom, irq;
  logic bus_rx = 0, wake = 0, trip = 0, main_ok = 1, io_ok = 1;
  cxf_bias_e bias;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int err_total = 0, total_checks = 0, cyc_cnt = 0;

  always #2.5 clk = ~clk;

  cxf_ctrl_model i_cxf_ctrl_model (.clk_in(clk), .txd_out(txd), .stb_out(stb));
  cxf_top #(.DTO_CYCLES(DTO)) i_cxf_top (.CLOCK_IN(clk), .SYS_RST_IN(rst),
    .TXD_IN(txd), .STANDBY_SELECT_IN(stb), .RXD_OUT(rxd), .RXD_OE_OUT(rxd_oe),
    .BUS_RX_DOMINANT_IN(bus_rx), .WAKE_DOMINANT_IN(wake), .THERMAL_TRIP_IN(trip),
    .MAIN_SUPPLY_OK_IN(main_ok), .IFACE_SUPPLY_OK_IN(io_ok), .DRIVER_EN_OUT(drv_en),
    .BUS_DOMINANT_OUT(bus_dom), .BUS_BIAS_OUT(bias), .IRQ_OUT(irq),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
    .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
    .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Outputs are read at the falling edge, once the rising edge has landed
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : at

  task automatic put(input logic t, input logic s);
    i_cxf_ctrl_model.put(t, s);
  endtask : put

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (awready && !a_ok) begin a_ok = 1; awvalid <= 1'h0; end
      if (wready && !w_ok) begin w_ok = 1; wvalid <= 1'h0; end
    end
    while (!bvalid) @(posedge clk);
    chk("bresp", bresp, er);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    chk("rdata", rdata & m, ed);
    chk("rresp", rresp, er);
    rready <= 1'h0;
  endtask : rd

  task automatic t_regs;
    rd(8'h00, 32'h0, 32'hffffffff, 2'h0);
    rd(8'h0c, 32'h0, 32'hffffffff, 2'h0);
    wr(8'h0c, 32'hffffffff, 2'h0);
    rd(8'h0c, 32'hf, 32'hffffffff, 2'h0);
    wr(8'h04, 32'hffffffff, 2'h0);
    rd(8'h04, 32'h4c, 32'hffffffff, 2'h0);
    wr(8'h00, 32'h2, 2'h0); at(1); chk("drv_kill", drv_en, 1'h0);
    rd(8'h00, 32'h2, 32'hffffffff, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h10, 32'h1, 2'h2);
    rd(8'h10, 32'h0, 32'hffffffff, 2'h2);
    wr(8'h0c, 32'h0, 2'h0);
    wr(8'h08, 32'hf, 2'h0);
  endtask : t_regs

  task automatic t_bits;
    i_cxf_ctrl_model.frame(11'h000, 1);
    at(2); chk("drv_en", drv_en, 1'h1);
    chk("bias", bias, BIAS_MID);
    put(1'h0, 1'h0); at(2); chk("bus_dom", bus_dom, 1'h1);
    put(1'h1, 1'h0); at(2); chk("bus_dom", bus_dom, 1'h0);
    @(posedge clk) bus_rx <= 1'h1; at(2); chk("rxd", rxd, 1'h0);
    @(posedge clk) bus_rx <= 1'h0; at(2); chk("rxd", rxd, 1'h1);
  endtask : t_bits

  // Timeout restart, fault, receive during fault, interrupt raise and clear
  task automatic t_dto;
    wr(8'h0c, 32'h1, 2'h0);
    put(1'h0, 1'h0); repeat (15) @(posedge clk);
    put(1'h1, 1'h0); put(1'h0, 1'h0); at(15); chk("drv_en", drv_en, 1'h1);
    at(10); chk("drv_en", drv_en, 1'h0);
    chk("irq", irq, 1'h1);
    @(posedge clk) bus_rx <= 1'h1; at(2); chk("rxd", rxd, 1'h0);
    @(posedge clk) bus_rx <= 1'h0; at(2); chk("rxd", rxd, 1'h1);
    rd(8'h04, 32'h10, 32'h10, 2'h0);
    rd(8'h08, 32'h1, 32'h1, 2'h0);
    put(1'h1, 1'h0); at(3); chk("drv_en", drv_en, 1'h1);
    wr(8'h08, 32'h1, 2'h0); at(2); chk("irq", irq, 1'h0);
  endtask : t_dto

  // Thermal fault with its interrupt masked out
  task automatic thermal_trip_threshold;
    @(posedge clk) trip <= 1'h1;
    put(1'h0, 1'h0); at(3);
    chk("drv_en", drv_en, 1'h0);
    chk("bus_dom", bus_dom, 1'h0);
    chk("irq", irq, 1'h0);
    @(posedge clk) bus_rx <= 1'h1; at(2); chk("rxd", rxd, 1'h0);
    @(posedge clk) bus_rx <= 1'h0;
    put(1'h1, 1'h0);
    @(posedge clk) trip <= 1'h0; at(100); chk("drv_en", drv_en, 1'h0);
    at(110); chk("drv_en", drv_en, 1'h1);
    @(posedge clk) trip <= 1'h1; at(3); chk("drv_en", drv_en, 1'h0);
    @(posedge clk) trip <= 1'h0; at(210);
    rd(8'h08, 32'h2, 32'h2, 2'h0);
    wr(8'h08, 32'hf, 2'h0);
  endtask : thermal_trip_threshold

  task automatic t_stby;
    wr(8'h0c, 32'h8, 2'h0);
    wr(8'h00, 32'h1, 2'h0); at(1); chk("bias", bias, BIAS_GND);
    wr(8'h00, 32'h0, 2'h0);
    put(1'h1, 1'h1); at(2);
    chk("bias", bias, BIAS_GND);
    chk("drv_en", drv_en, 1'h0);
    chk("rxd", rxd, 1'h1);
    @(posedge clk) wake <= 1'h1; at(2); chk("rxd", rxd, 1'h0);
    chk("irq", irq, 1'h1);
    @(posedge clk) wake <= 1'h0;
    put(1'h1, 1'h0); at(SETTLE); chk("drv_en", drv_en, 1'h1);
    wr(8'h08, 32'hf, 2'h0);
  endtask : t_stby

  task automatic t_uv;
    wr(8'h0c, 32'h4, 2'h0);
    @(posedge clk) main_ok <= 1'h0; at(2);
    chk("bias", bias, BIAS_HIZ);
    chk("rxd", rxd, 1'h1);
    chk("drv_en", drv_en, 1'h0);
    chk("irq", irq, 1'h1);
    @(posedge clk) io_ok <= 1'h0; at(2); chk("rxd_oe", rxd_oe, 1'h0);
    @(posedge clk) begin
      io_ok <= 1'h1;
      main_ok <= 1'h1;
    end
    at(100); chk("drv_en", drv_en, 1'h0);
    at(SETTLE); chk("drv_en", drv_en, 1'h1);
    chk("rxd_oe", rxd_oe, 1'h1);
    wr(8'h08, 32'hf, 2'h0);
  endtask : t_uv

  // Whole run is about 13000 cycles
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    at(SETTLE); chk("drv_en", drv_en, 1'h1);
    t_regs();
    t_bits();
    t_dto();
    thermal_trip_threshold();
    t_stby();
    t_uv();
    stop_test();
  end
endmodule : cxf_top_bench

// ==== tb/cxf_top_monitor.sv ====
// Checker of the fault-control pins of cxf_top.
// Sees only the top ports; bound to every cxf_top instance below.
module cxf_top_monitor
  import cxf_pkg::*;
#(
  parameter int DTO_CYCLES = 20
) (
  // Clock and reset
  input wire logic       CLOCK_IN,
  input wire logic       SYS_RST_IN,
  // Controller side
  input wire logic       TXD_IN,
  input wire logic       STANDBY_SELECT_IN,
  input wire logic       RXD_OUT,
  input wire logic       RXD_OE_OUT,
  // Analog front end
  input wire logic       BUS_RX_DOMINANT_IN,
  input wire logic       THERMAL_TRIP_IN,
  input wire logic       MAIN_SUPPLY_OK_IN,
  input wire logic       IFACE_SUPPLY_OK_IN,
  input wire logic       DRIVER_EN_OUT,
  input wire logic       BUS_DOMINANT_OUT,
  input wire cxf_bias_e  BUS_BIAS_OUT
);
  import cxf_pkg::*;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // Cycles of continuous low transmit, saturating to stay small
  logic [31:0] low_cnt;
  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      low_cnt <= 32'h0;
    end else if (TXD_IN) begin
      low_cnt <= 32'h0;
    end else if (low_cnt < DTO_CYCLES + 8) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  AST_RXD_OE: assert property (!IFACE_SUPPLY_OK_IN |=> !RXD_OE_OUT)
    else $error("receive output driven without interface supply");
  AST_REC: assert property (DRIVER_EN_OUT && $past(TXD_IN) |-> !BUS_DOMINANT_OUT)
    else $error("recessive transmit drove the bus dominant");
  AST_FOLLOW: assert property (DRIVER_EN_OUT && RXD_OE_OUT
    |-> RXD_OUT == !$past(BUS_RX_DOMINANT_IN)) else $error("receive not mirroring bus");
  AST_STBY: assert property (STANDBY_SELECT_IN && IFACE_SUPPLY_OK_IN
    |=> BUS_BIAS_OUT == BIAS_GND && !DRIVER_EN_OUT) else $error("standby bias wrong");
  AST_PROT: assert property (!MAIN_SUPPLY_OK_IN && !STANDBY_SELECT_IN && IFACE_SUPPLY_OK_IN
    |=> BUS_BIAS_OUT == BIAS_HIZ && RXD_OUT) else $error("protected state wrong");
  AST_THERM_OFF: assert property (THERMAL_TRIP_IN |-> ##2 !DRIVER_EN_OUT)
    else $error("driver on during thermal fault");
  AST_THERM_HOLD: assert property ($fell(THERMAL_TRIP_IN) |=> !DRIVER_EN_OUT [*8])
    else $error("thermal release without hysteresis");
  AST_SETTLE: assert property ($rose(MAIN_SUPPLY_OK_IN) |=> !DRIVER_EN_OUT [*8])
    else $error("driver back before mode change time");
  AST_DTO: assert property (low_cnt == DTO_CYCLES + 3 |-> !DRIVER_EN_OUT)
    else $error("driver still on after dominant timeout");
endmodule : cxf_top_monitor

bind cxf_top cxf_top_monitor #(.DTO_CYCLES(DTO_CYCLES)) i_cxf_top_monitor (.*);
